/* src/rdl_pkg.sv */
// package for the power-mode sequencer and emitter drive control
package rdl_pkg;
  // ==========================================================================
  // register offsets
  localparam logic [6:0] ADDR_RUN_CFG       = 7'h12;
  localparam logic [6:0] ADDR_MOTION        = 7'h02;
  localparam logic [6:0] ADDR_MOTION_ALT    = 7'h42;
  localparam logic [6:0] ADDR_RUN_IDLE      = 7'h13;
  localparam logic [6:0] ADDR_REST1_PERIOD  = 7'h14;
  localparam logic [6:0] ADDR_REST1_IDLE    = 7'h15;
  localparam logic [6:0] ADDR_REST2_PERIOD  = 7'h16;
  localparam logic [6:0] ADDR_REST2_IDLE    = 7'h17;
  localparam logic [6:0] ADDR_REST3_PERIOD  = 7'h18;
  localparam logic [6:0] ADDR_EMIT_CTRL     = 7'h1a;
  localparam logic [6:0] ADDR_EMIT_CTRL_CPL = 7'h1f;
  localparam logic [6:0] ADDR_OBSERVE       = 7'h2e;
  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_RUN_CFG       = 8'h26;
  localparam logic [7:0] RST_RUN_IDLE      = 8'h04;
  localparam logic [7:0] RST_REST1_PERIOD  = 8'h01;
  localparam logic [7:0] RST_REST1_IDLE    = 8'h1f;
  localparam logic [7:0] RST_REST2_PERIOD  = 8'h09;
  localparam logic [7:0] RST_REST2_IDLE    = 8'h2f;
  localparam logic [7:0] RST_REST3_PERIOD  = 8'h31;
  localparam logic [7:0] RST_EMIT_CTRL     = 8'h00;
  localparam logic [7:0] RST_EMIT_CTRL_CPL = 8'h00;
  // ==========================================================================
  // field positions
  localparam int RANGE_MSB     = 7;
  localparam int RANGE_LSB     = 6;
  localparam int CAL_MSB       = 3;
  localparam int CAL_LSB       = 1;
  localparam int KILL_BIT      = 0;
  localparam int STAY_BIT      = 3;
  localparam int RUN_RATE_MSB  = 2;
  localparam int MODE_MSB      = 7;
  localparam int MODE_LSB      = 6;
  localparam int CFG_OK_BIT    = 5;
  localparam logic [2:0] CAL_CW  = 3'h5;
  localparam logic [2:0] CAL_OFF = 3'h0;
  localparam logic [1:0] RANGE_BAD = 2'h2;
  // ==========================================================================
  // timing
  localparam int SYS_CLK_HZ     = 100_000_000;
  localparam int MS_PER_S       = 1000;
  localparam int CYC_PER_MS     = SYS_CLK_HZ / MS_PER_S;
  localparam int RUN_BASE_MS    = 2;
  localparam int HIB_PERIOD_MS  = 10;
  localparam int RUN_MULT       = 8;
  localparam int REST1_MULT     = 16;
  localparam int REST2_MULT     = 128;
  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    RDL_RUN,
    RDL_REST1,
    RDL_REST2,
    RDL_REST3
  } rdl_mode_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } rdl_req_t;
endpackage

/* src/rdl_core.sv */
// power-mode sequencer and emitter drive control
`timescale 1ns/1ps
`default_nettype none
module rdl_core #(
  parameter int HIB_DIV = rdl_pkg::HIB_PERIOD_MS * rdl_pkg::CYC_PER_MS
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire rdl_pkg::rdl_req_t req,
  output logic [7:0]            rdata,
  input  wire logic             motion_seen,
  output logic                  frame_strobe,
  output rdl_pkg::rdl_mode_t    power_mode,
  output logic                  emitter_cfg_ok,
  output logic                  emitter_enable_n
);
  initial begin
    if (HIB_DIV < 2) $error("HIB_DIV must be at least 2");
  end
  // ==========================================================================
  // registers
  logic [7:0] run_cfg_q, run_cfg_d;
  logic [7:0] run_idle_frames_q, run_idle_frames_d;
  logic [7:0] rest_one_period_q, rest_one_period_d;
  logic [7:0] rest_one_idle_frames_q, rest_one_idle_frames_d;
  logic [7:0] rest_two_period_q, rest_two_period_d;
  logic [7:0] rest_two_idle_frames_q, rest_two_idle_frames_d;
  logic [7:0] rest_three_period_q, rest_three_period_d;
  logic [7:0] emitter_drive_control_q, emitter_drive_control_d;
  logic [7:0] emitter_drive_cpl_q, emitter_drive_cpl_d;
  logic       motion_rd;
  assign motion_rd = req.rd && (req.addr == rdl_pkg::ADDR_MOTION ||
                                req.addr == rdl_pkg::ADDR_MOTION_ALT);
  always_comb begin
    run_cfg_d               = run_cfg_q;
    run_idle_frames_d       = run_idle_frames_q;
    rest_one_period_d       = rest_one_period_q;
    rest_one_idle_frames_d  = rest_one_idle_frames_q;
    rest_two_period_d       = rest_two_period_q;
    rest_two_idle_frames_d  = rest_two_idle_frames_q;
    rest_three_period_d     = rest_three_period_q;
    emitter_drive_control_d = emitter_drive_control_q;
    emitter_drive_cpl_d     = emitter_drive_cpl_q;
    if (req.wr) begin
      if (req.addr == rdl_pkg::ADDR_RUN_CFG) begin
        run_cfg_d = {1'b0, req.wdata[6:0]};
      end else if (req.addr == rdl_pkg::ADDR_RUN_IDLE) begin
        run_idle_frames_d = req.wdata;
      end else if (req.addr == rdl_pkg::ADDR_REST1_PERIOD) begin
        rest_one_period_d = req.wdata;
      end else if (req.addr == rdl_pkg::ADDR_REST1_IDLE) begin
        rest_one_idle_frames_d = req.wdata;
      end else if (req.addr == rdl_pkg::ADDR_REST2_PERIOD) begin
        rest_two_period_d = req.wdata;
      end else if (req.addr == rdl_pkg::ADDR_REST2_IDLE) begin
        rest_two_idle_frames_d = req.wdata;
      end else if (req.addr == rdl_pkg::ADDR_REST3_PERIOD) begin
        rest_three_period_d = req.wdata;
      end else if (req.addr == rdl_pkg::ADDR_EMIT_CTRL) begin
        emitter_drive_control_d = {req.wdata[7:6], 2'b00, req.wdata[3:0]};
      end else if (req.addr == rdl_pkg::ADDR_EMIT_CTRL_CPL) begin
        emitter_drive_cpl_d = {req.wdata[7:6], 6'h00};
      end
    end
    if (motion_rd) begin
      emitter_drive_control_d[rdl_pkg::CAL_MSB:rdl_pkg::CAL_LSB] = rdl_pkg::CAL_OFF;
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      run_cfg_q               <= rdl_pkg::RST_RUN_CFG;
      run_idle_frames_q       <= rdl_pkg::RST_RUN_IDLE;
      rest_one_period_q       <= rdl_pkg::RST_REST1_PERIOD;
      rest_one_idle_frames_q  <= rdl_pkg::RST_REST1_IDLE;
      rest_two_period_q       <= rdl_pkg::RST_REST2_PERIOD;
      rest_two_idle_frames_q  <= rdl_pkg::RST_REST2_IDLE;
      rest_three_period_q     <= rdl_pkg::RST_REST3_PERIOD;
      emitter_drive_control_q <= rdl_pkg::RST_EMIT_CTRL;
      emitter_drive_cpl_q     <= rdl_pkg::RST_EMIT_CTRL_CPL;
    end else begin
      run_cfg_q               <= run_cfg_d;
      run_idle_frames_q       <= run_idle_frames_d;
      rest_one_period_q       <= rest_one_period_d;
      rest_one_idle_frames_q  <= rest_one_idle_frames_d;
      rest_two_period_q       <= rest_two_period_d;
      rest_two_idle_frames_q  <= rest_two_idle_frames_d;
      rest_three_period_q     <= rest_three_period_d;
      emitter_drive_control_q <= emitter_drive_control_d;
      emitter_drive_cpl_q     <= emitter_drive_cpl_d;
    end
  end
  // ==========================================================================
  // emitter drive
  logic [1:0] range_bits;
  logic [1:0] range_cpl;
  assign range_bits = emitter_drive_control_q[rdl_pkg::RANGE_MSB:rdl_pkg::RANGE_LSB];
  assign range_cpl  = emitter_drive_cpl_q[rdl_pkg::RANGE_MSB:rdl_pkg::RANGE_LSB];
  logic cfg_ok_d, cfg_ok_q;
  logic en_n_d, en_n_q;
  logic cw_mode;
  logic frame_tick;
  assign cw_mode = emitter_drive_control_q[rdl_pkg::CAL_MSB:rdl_pkg::CAL_LSB] == rdl_pkg::CAL_CW;
  always_comb begin
    cfg_ok_d = (range_bits == ~range_cpl) && (range_bits != rdl_pkg::RANGE_BAD);
    if (emitter_drive_control_q[rdl_pkg::KILL_BIT] || !cfg_ok_d) begin
      en_n_d = 1'b1;
    end else if (cw_mode) begin
      en_n_d = 1'b0;
    end else begin
      en_n_d = ~frame_tick;
    end
  end
  // ==========================================================================
  // frame timing
  localparam int HW = $clog2(HIB_DIV + 1);
  logic [HW-1:0]  hib_cnt_q, hib_cnt_d;
  logic           hib_tick;
  logic [7:0]     rest_cnt_q, rest_cnt_d;
  logic [19:0]    run_cnt_q, run_cnt_d;
  logic [19:0]    run_len;
  logic [7:0]     rest_code;
  logic [15:0]    idle_q, idle_d;
  logic [15:0]    idle_lim;
  rdl_pkg::rdl_mode_t mode_q, mode_d;
  assign hib_tick = hib_cnt_q == HW'(HIB_DIV - 1);
  always_comb begin
    run_len = 20'((32'(run_cfg_q[rdl_pkg::RUN_RATE_MSB:0]) + rdl_pkg::RUN_BASE_MS)
                  * rdl_pkg::CYC_PER_MS);
    case (mode_q)
      rdl_pkg::RDL_REST1: rest_code = rest_one_period_q;
      rdl_pkg::RDL_REST2: rest_code = rest_two_period_q;
      default:   rest_code = rest_three_period_q;
    endcase
    if (mode_q == rdl_pkg::RDL_RUN) begin
      frame_tick = run_cnt_q >= run_len - 20'h1;
    end else begin
      frame_tick = hib_tick && rest_cnt_q >= rest_code;
    end
    case (mode_q)
      rdl_pkg::RDL_RUN:   idle_lim = 16'(run_idle_frames_q) * 16'(rdl_pkg::RUN_MULT);
      rdl_pkg::RDL_REST1: idle_lim = 16'(rest_one_idle_frames_q)
                                     * 16'(rdl_pkg::REST1_MULT);
      default:   idle_lim = 16'(rest_two_idle_frames_q) * 16'(rdl_pkg::REST2_MULT);
    endcase
    hib_cnt_d  = hib_tick ? '0 : hib_cnt_q + HW'(1);
    run_cnt_d  = (mode_q != rdl_pkg::RDL_RUN || frame_tick) ? 20'h0 : run_cnt_q + 20'h1;
    rest_cnt_d = rest_cnt_q;
    if (mode_q == rdl_pkg::RDL_RUN || frame_tick) begin
      rest_cnt_d = 8'h0;
    end else if (hib_tick) begin
      rest_cnt_d = rest_cnt_q + 8'h1;
    end
    mode_d = mode_q;
    idle_d = idle_q;
    if (motion_seen) begin
      mode_d = rdl_pkg::RDL_RUN;
      idle_d = 16'h0;
    end else if (run_cfg_q[rdl_pkg::STAY_BIT]) begin
      mode_d = rdl_pkg::RDL_RUN;
      idle_d = 16'h0;
    end else if (frame_tick) begin
      if (mode_q != rdl_pkg::RDL_REST3 && idle_q + 16'h1 >= idle_lim) begin
        idle_d = 16'h0;
        case (mode_q)
          rdl_pkg::RDL_RUN:   mode_d = rdl_pkg::RDL_REST1;
          rdl_pkg::RDL_REST1: mode_d = rdl_pkg::RDL_REST2;
          default:            mode_d = rdl_pkg::RDL_REST3;
        endcase
      end else if (mode_q != rdl_pkg::RDL_REST3) begin
        idle_d = idle_q + 16'h1;
      end
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hib_cnt_q <= '0;
      run_cnt_q <= 20'h0;
      rest_cnt_q <= 8'h0;
      idle_q    <= 16'h0;
      mode_q    <= rdl_pkg::RDL_RUN;
      cfg_ok_q  <= 1'b0;
      en_n_q    <= 1'b1;
    end else begin
      hib_cnt_q <= hib_cnt_d;
      run_cnt_q <= run_cnt_d;
      rest_cnt_q <= rest_cnt_d;
      idle_q    <= idle_d;
      mode_q    <= mode_d;
      cfg_ok_q  <= cfg_ok_d;
      en_n_q    <= en_n_d;
    end
  end
  assign frame_strobe     = frame_tick;
  assign power_mode       = mode_q;
  assign emitter_cfg_ok   = cfg_ok_q;
  assign emitter_enable_n = en_n_q;
  // ==========================================================================
  // read mux
  always_comb begin
    rdata = 8'h00;
    if (req.addr == rdl_pkg::ADDR_RUN_CFG) begin
      rdata = run_cfg_q;
    end else if (req.addr == rdl_pkg::ADDR_MOTION || req.addr == rdl_pkg::ADDR_MOTION_ALT) begin
      rdata = 8'h00;
      rdata[rdl_pkg::CFG_OK_BIT] = cfg_ok_q;
    end else if (req.addr == rdl_pkg::ADDR_RUN_IDLE) begin
      rdata = run_idle_frames_q;
    end else if (req.addr == rdl_pkg::ADDR_REST1_PERIOD) begin
      rdata = rest_one_period_q;
    end else if (req.addr == rdl_pkg::ADDR_REST1_IDLE) begin
      rdata = rest_one_idle_frames_q;
    end else if (req.addr == rdl_pkg::ADDR_REST2_PERIOD) begin
      rdata = rest_two_period_q;
    end else if (req.addr == rdl_pkg::ADDR_REST2_IDLE) begin
      rdata = rest_two_idle_frames_q;
    end else if (req.addr == rdl_pkg::ADDR_REST3_PERIOD) begin
      rdata = rest_three_period_q;
    end else if (req.addr == rdl_pkg::ADDR_EMIT_CTRL) begin
      rdata = emitter_drive_control_q;
    end else if (req.addr == rdl_pkg::ADDR_EMIT_CTRL_CPL) begin
      rdata = emitter_drive_cpl_q;
    end else if (req.addr == rdl_pkg::ADDR_OBSERVE) begin
      rdata = {mode_q, 6'h00};
    end
  end
endmodule
`default_nettype wire

/* test/rdl_core_assertions.sv */
// checker for the power-mode sequencer and emitter drive control
`timescale 1ns/1ps
`default_nettype none
module rdl_core_chk #(
  parameter int HIB_DIV = 10
) (
  input wire logic               sys_clk,
  input wire logic               reset,
  input wire rdl_pkg::rdl_req_t  req,
  input wire logic [7:0]         rdata,
  input wire logic               motion_seen,
  input wire logic               frame_strobe,
  input wire rdl_pkg::rdl_mode_t power_mode,
  input wire logic               emitter_cfg_ok,
  input wire logic               emitter_enable_n
);
  logic [7:0] ctl_q, ctl_d, cpl_q, cpl_d;
  logic       stay_q, stay_d, ok_exp, mrd;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ==========================================================================
  // shadow copies of the emitter and stay settings
  assign mrd = req.rd && (req.addr == 7'h02 || req.addr == 7'h42);
  assign ok_exp = ctl_q[7:6] == ~cpl_q[7:6] && ctl_q[7:6] != 2'h2;
  always_comb begin
    ctl_d = mrd ? {ctl_q[7:4], 3'h0, ctl_q[0]} : ctl_q;
    cpl_d = cpl_q;
    stay_d = stay_q;
    if (req.wr && req.addr == 7'h1a) ctl_d = req.wdata & 8'hcf;
    if (req.wr && req.addr == 7'h1f) cpl_d = req.wdata & 8'hc0;
    if (req.wr && req.addr == 7'h12) stay_d = req.wdata[3];
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctl_q <= 8'h00;
      cpl_q <= 8'h00;
      stay_q <= 1'h0;
    end else begin
      ctl_q <= ctl_d;
      cpl_q <= cpl_d;
      stay_q <= stay_d;
    end
  end
  // ==========================================================================
  // properties
  sequence s_motion_rd;
    mrd;
  endsequence
  a_motion_rd_cal: assert property (s_motion_rd ##1 req.addr == 7'h1a |-> rdata[3:1] == 3'h0)
    else $error("cal field kept after motion read");
  a_cfg_ok_match: assert property (1'h1 |=> emitter_cfg_ok == $past(ok_exp))
    else $error("config ok flag wrong");
  a_range_bad_flag: assert property (ctl_q[7:6] == 2'h2 |=> !emitter_cfg_ok)
    else $error("invalid range reported ok");
  a_bad_cfg_off: assert property (!ok_exp |=> emitter_enable_n)
    else $error("emitter on with bad config");
  a_kill_holds_off: assert property (ctl_q[0] |=> emitter_enable_n)
    else $error("emitter on while killed");
  a_cw_steady_on: assert property (ok_exp && ctl_q[3:1] == 3'h5 && !ctl_q[0] |=> !emitter_enable_n)
    else $error("emitter not on in cw mode");
  a_motion_to_run: assert property (motion_seen |=> power_mode == rdl_pkg::RDL_RUN)
    else $error("no return to run on motion");
  a_stay_holds_run: assert property (stay_q && power_mode == rdl_pkg::RDL_RUN |=> power_mode == rdl_pkg::RDL_RUN)
    else $error("left run while stay set");
  a_mode_steps: assert property ($changed(power_mode) && power_mode != rdl_pkg::RDL_RUN
    |-> $past(frame_strobe) && power_mode == $past(power_mode) + 2'h1)
    else $error("illegal mode step");
  a_mode_readback: assert property (req.addr == 7'h2e |-> rdata[7:6] == power_mode)
    else $error("mode readback wrong");
endmodule
bind rdl_core rdl_core_chk #(.HIB_DIV(HIB_DIV)) u_chk (
  .sys_clk(sys_clk), .reset(reset), .req(req), .rdata(rdata),
  .motion_seen(motion_seen), .frame_strobe(frame_strobe), .power_mode(power_mode),
  .emitter_cfg_ok(emitter_cfg_ok), .emitter_enable_n(emitter_enable_n)
);
`default_nettype wire

/* test/rdl_host.sv */
// register bus host model standing in for the external controller
`timescale 1ns/1ps
`default_nettype none
module rdl_host (
  input  wire logic            sys_clk,
  input  wire logic [7:0]      rdata,
  output var rdl_pkg::rdl_req_t req
);
  initial req = '0;
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req <= '{1'h1, 1'h0, a, d};
    @(posedge sys_clk);
  endtask
  // read data is combinational, so it is taken once the address has settled
  task automatic rd(input logic [6:0] a, output logic [7:0] q);
    @(negedge sys_clk);
    req <= '{1'h0, 1'h1, a, 8'h00};
    #1 q = rdata;
    @(posedge sys_clk);
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      req <= '0;
      @(posedge sys_clk);
    end
    #1;
  endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the power-mode sequencer and emitter drive control
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  logic               sys_clk, reset, motion_seen, frame_strobe, emitter_cfg_ok, emitter_enable_n;
  logic [7:0]         rdata, q, d;
  logic [1:0]         c, k;
  rdl_pkg::rdl_req_t  req;
  rdl_pkg::rdl_mode_t power_mode;
  int                 n_fail, comparisons;
  logic [6:0]         ad [10] = '{7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h18, 7'h1a, 7'h1f, 7'h19};
  logic [7:0]         rv [10] = '{8'h26, 8'h04, 8'h01, 8'h1f, 8'h09, 8'h2f, 8'h31, 8'h00, 8'h00, 8'h00};
  rdl_core #(.HIB_DIV(10)) u_dut (
    .sys_clk(sys_clk), .reset(reset), .req(req), .rdata(rdata), .motion_seen(motion_seen),
    .frame_strobe(frame_strobe), .power_mode(power_mode), .emitter_cfg_ok(emitter_cfg_ok),
    .emitter_enable_n(emitter_enable_n)
  );
  rdl_host u_host (.sys_clk(sys_clk), .rdata(rdata), .req(req));
  function automatic logic exp_ok(logic [1:0] cr, logic [1:0] kr);
    return cr == ~kr && cr != 2'h2;
  endfunction
  task automatic finish_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) motion_seen <= ($urandom % 8) == 0;
  initial begin
    #200_000;
    n_fail++;
    finish_test();
  end
  initial begin
    void'($urandom(88057));
    reset = 1'h1;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk) reset = 1'h0;
    foreach (ad[i]) begin
      u_host.rd(ad[i], q);
      `CHK("reset value", rv[i], q)
    end
    for (int i = 1; i < 7; i++) begin
      d = 8'h02 + 8'($urandom % 240);
      u_host.wr(ad[i], d);
      u_host.rd(ad[i], q);
      `CHK("rw register", d, q)
    end
    d = 8'($urandom);
    u_host.wr(7'h1a, d);
    u_host.rd(7'h1a, q);
    `CHK("emitter ctrl", d & 8'hcf, q)
    $display("test registers done");
    for (int r = 0; r < 4; r++) begin
      c = 2'(r);
      k = ~c;
      if (r % 2 == 1) u_host.wr(7'h1f, {k, 6'h00});
      u_host.wr(7'h1a, {c, 6'h00});
      if (r % 2 == 0) u_host.wr(7'h1f, {k, 6'h00});
      u_host.idle(2);
      `CHK("cfg ok", exp_ok(c, k), emitter_cfg_ok)
    end
    u_host.wr(7'h1f, 8'hc0);
    u_host.idle(2);
    `CHK("cfg mismatch", 1'h0, emitter_cfg_ok)
    $display("test range done");
    for (int i = 0; i < 2; i++) begin
      u_host.wr(7'h1f, 8'h00);
      u_host.wr(7'h1a, 8'hca);
      u_host.idle(2);
      `CHK("cw on", 1'h0, emitter_enable_n)
      u_host.rd(i == 0 ? 7'h02 : 7'h42, q);
      u_host.rd(7'h1a, q);
      `CHK("cal cleared", 3'h0, q[3:1])
      u_host.idle(2);
      `CHK("cw ended", 1'h1, emitter_enable_n)
    end
    u_host.wr(7'h1a, 8'hcb);
    u_host.idle(2);
    `CHK("killed", 1'h1, emitter_enable_n)
    u_host.wr(7'h1f, 8'h40);
    u_host.wr(7'h1a, 8'h8a);
    u_host.idle(2);
    `CHK("bad range off", 1'h1, emitter_enable_n)
    $display("test emitter done");
    u_host.wr(7'h12, 8'h20);
    u_host.rd(7'h12, q);
    `CHK("stay off", 8'h20, q)
    repeat (20) begin
      u_host.rd(7'h2e, q);
      `CHK("mode run", 2'h0, q[7:6])
    end
    $display("test mode done");
    finish_test();
  end
endmodule
`default_nettype wire
